//--- pkg/trace_pkg.sv
package trace_pkg;

	// ------------------------------------------------------------
	// sizes
	// ------------------------------------------------------------
	localparam int FRAME_W  = 39;
	localparam int Q_DEPTH  = 16;
	localparam int Q_PTR_W  = 4;
	localparam int ADDR_W   = 8;
	localparam int N_BKPT   = 8;
	localparam int N_SRC    = 7;

	// ------------------------------------------------------------
	// register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] REG_CTRL   = 8'h00;
	localparam logic [7:0] REG_WPEN   = 8'h04;
	localparam logic [7:0] REG_HALTEN = 8'h08;
	localparam logic [7:0] REG_D0LO   = 8'h0C;
	localparam logic [7:0] REG_D0HI   = 8'h10;
	localparam logic [7:0] REG_D1LO   = 8'h14;
	localparam logic [7:0] REG_D1HI   = 8'h18;
	localparam logic [7:0] REG_PID    = 8'h1C;
	localparam logic [7:0] REG_MTBASE = 8'h20;
	localparam logic [7:0] REG_MTSIZE = 8'h24;
	localparam logic [7:0] REG_STATUS = 8'h28;

	// ------------------------------------------------------------
	// control register fields and reset values
	// ------------------------------------------------------------
	localparam int CB_PROG   = 0;
	localparam int CB_DATA0  = 1;
	localparam int CB_DATA1  = 2;
	localparam int CB_OWN    = 3;
	localparam int CB_DBGST  = 4;
	localparam int CB_STALL  = 5;
	localparam int CB_EVBRK  = 6;
	localparam int CB_EVSYNC = 7;
	localparam int CB_EVTO   = 8;
	localparam int CB_MEMTR  = 10;
	localparam int CB_D0WP   = 11;
	localparam int CB_D1WP   = 12;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] MTSIZE_RST = 32'h0000_0000;
	localparam logic [31:0] MT_STEP = 32'h0000_0008;

	localparam logic [1:0] EVTO_OFF = 2'h0;
	localparam logic [1:0] EVTO_MSG = 2'h1;
	localparam logic [1:0] EVTO_BRK = 2'h2;

	// ------------------------------------------------------------
	// message sources, lower index wins
	// ------------------------------------------------------------
	localparam int SRC_ERR  = 0;
	localparam int SRC_DBG  = 1;
	localparam int SRC_OWN  = 2;
	localparam int SRC_WP   = 3;
	localparam int SRC_SYNC = 4;
	localparam int SRC_DATA = 5;
	localparam int SRC_PROG = 6;

	localparam logic [5:0] TC_DBG  = 6'h00;
	localparam logic [5:0] TC_OWN  = 6'h02;
	localparam logic [5:0] TC_PROG = 6'h04;
	localparam logic [5:0] TC_ERR  = 6'h08;
	localparam logic [5:0] TC_SYNC = 6'h09;
	localparam logic [5:0] TC_WP   = 6'h0F;
	localparam logic [2:0] TC_DATA = 3'h2;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_SEND = 1'b1
	} seq_state_type;

endpackage

//--- verilog/trace_frame_queue.sv
`timescale 1ns/1ps
`default_nettype none
module trace_frame_queue (
	input  wire logic                         clk,
	input  wire logic                         rst,
	input  wire logic                         inValid,
	output logic                              inReady,
	input  wire logic [trace_pkg::FRAME_W-1:0] inFrame,
	output logic                              outValid,
	input  wire logic                         outReady,
	output logic [trace_pkg::FRAME_W-1:0]     outFrame,
	output logic [trace_pkg::Q_PTR_W:0]       level
);
	import trace_pkg::*;

	logic [FRAME_W-1:0] store_r [Q_DEPTH];
	logic [Q_PTR_W-1:0] wrPtr_r;
	logic [Q_PTR_W-1:0] rdPtr_r;
	logic [Q_PTR_W:0]   cnt_r;
	wire                push = inValid && inReady;
	wire                pop  = outValid && outReady;

	assign inReady  = (cnt_r != Q_PTR_W'(0) + (Q_PTR_W+1)'(Q_DEPTH));
	assign outValid = (cnt_r != '0);
	assign outFrame = store_r[rdPtr_r];
	assign level    = cnt_r;

	always_ff @(posedge clk) begin
		if (push)
			store_r[wrPtr_r] <= inFrame;
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			cnt_r   <= '0;
		end else begin
			wrPtr_r <= wrPtr_r + Q_PTR_W'(push);
			rdPtr_r <= rdPtr_r + Q_PTR_W'(pop);
			cnt_r   <= cnt_r + (Q_PTR_W+1)'(push) - (Q_PTR_W+1)'(pop);
		end
	end

	a_queue_bound: assert property (@(posedge clk) disable iff (rst) // [R3]
		cnt_r <= (Q_PTR_W+1)'(Q_DEPTH)) else $error("queue count above depth");

endmodule // trace_frame_queue
`default_nettype wire

//--- verilog/debug_trace_message_unit.sv
// Notes on behaviour
// R1 - no message source acts until its enable bit is written by the debugger
// R2 - trace is compressed and packed into one or two frame messages
// R3 - messages pass a sixteen frame queue and leave one frame per transfer
// R4 - an event lost while its slot is busy queues an error message
// R5 - stall option holds the CPU while the queue or slots are busy
// R6 - each branch gives a program message naming source and target compressed
// R7 - data message gives direction, size, address and data of watched access
// R8 - two data channels, each bounded by a low and high address register
// R9 - all comparisons take the virtual addresses seen by the CPU
// R10 - writing the process identifier register queues an ownership message
// R11 - comparators give watchpoints and halts under separate enable masks
// R12 - a data channel can give a watchpoint in place of data trace
// R13 - event input can raise a breakpoint that puts the CPU in debug mode
// R14 - event input can queue program and data synchronisation message
// R15 - each debug mode entry queues a debug status message
// R16 - event output can toggle on every message placed in the queue
// R17 - event output can toggle on comparator trigger or debug entry
// R18 - sync messages carry full addresses so the tool tracks the PC alone
// R19 - memory trace mode writes frames to a wrapping buffer at base and size
// R20 - software keeps out of the memory trace buffer area
// R21 - runs on the debug clock, synchronous to the CPU clock
// R22 - event pins are active low; input is synchronised and edge detected
//
// The address-and-strobe port and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module debug_trace_message_unit (
	input  wire logic                              clk, // [R21]
	input  wire logic                              rst,
	input  wire logic [trace_pkg::ADDR_W-1:0]      regAddr,
	input  wire logic [31:0]                       regWrData,
	input  wire logic                              regWr,
	input  wire logic                              regRd,
	output logic [31:0]                            regRdData,
	input  wire logic                              cpuBranch,
	input  wire logic [31:0]                       cpuBranchSrc,
	input  wire logic [31:0]                       cpuBranchDst,
	input  wire logic                              cpuMemAcc,
	input  wire logic                              cpuMemWrite,
	input  wire logic [1:0]                        cpuMemSize,
	input  wire logic [31:0]                       cpuMemAddr,
	input  wire logic [31:0]                       cpuMemData,
	input  wire logic [trace_pkg::N_BKPT-1:0]      bkptTrig,
	input  wire logic                              cpuDebugEntry,
	output logic                                   cpuStall,
	output logic                                   cpuBreakReq,
	input  wire logic                              externalEventInN,
	output logic                                   eventOutputToggleN,
	output logic                                   auxValid,
	input  wire logic                              auxReady,
	output logic [trace_pkg::FRAME_W-1:0]          auxFrame,
	output logic                                   memWrValid,
	input  wire logic                              memWrReady,
	output logic [31:0]                            memWrAddr,
	output logic [trace_pkg::FRAME_W-1:0]          memWrData
);
	import trace_pkg::*;

	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	logic [31:0] ctrl_r, wpEn_r, haltEn_r, pid_r, mtBase_r, mtSize_r, mtOff_r;
	logic [31:0] chLo_r [2];
	logic [31:0] chHi_r [2];
	logic        ovf_r;
	logic [Q_PTR_W:0] qLevel;

	function automatic logic hitReg(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	function automatic logic inRange(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
		return (hi == lo) ? (a == lo) : (a >= lo && a <= hi);
	endfunction

	wire wrCtrl = regWr && hitReg(regAddr, REG_CTRL);
	wire wrPid  = regWr && hitReg(regAddr, REG_PID);
	wire [31:0] statusWord = {16'h0000, 7'h00, ovf_r, 3'h0, qLevel};
	wire [31:0] rdMux =
		hitReg(regAddr, REG_CTRL)   ? ctrl_r :
		hitReg(regAddr, REG_WPEN)   ? wpEn_r :
		hitReg(regAddr, REG_HALTEN) ? haltEn_r :
		hitReg(regAddr, REG_D0LO)   ? chLo_r[0] :
		hitReg(regAddr, REG_D0HI)   ? chHi_r[0] :
		hitReg(regAddr, REG_D1LO)   ? chLo_r[1] :
		hitReg(regAddr, REG_D1HI)   ? chHi_r[1] :
		hitReg(regAddr, REG_PID)    ? pid_r :
		hitReg(regAddr, REG_MTBASE) ? mtBase_r :
		hitReg(regAddr, REG_MTSIZE) ? mtSize_r :
		hitReg(regAddr, REG_STATUS) ? statusWord : 32'h0000_0000;

	always_ff @(posedge clk) begin
		if (rst) begin
			ctrl_r    <= CTRL_RST;
			wpEn_r    <= '0;
			haltEn_r  <= '0;
			pid_r     <= '0;
			mtBase_r  <= '0;
			mtSize_r  <= MTSIZE_RST;
			chLo_r[0] <= '0;
			chHi_r[0] <= '0;
			chLo_r[1] <= '0;
			chHi_r[1] <= '0;
			regRdData <= '0;
		end else begin
			if (wrCtrl) ctrl_r <= regWrData; // [R1]
			if (regWr && hitReg(regAddr, REG_WPEN))   wpEn_r <= regWrData;
			if (regWr && hitReg(regAddr, REG_HALTEN)) haltEn_r <= regWrData;
			if (regWr && hitReg(regAddr, REG_D0LO))   chLo_r[0] <= regWrData;
			if (regWr && hitReg(regAddr, REG_D0HI))   chHi_r[0] <= regWrData;
			if (regWr && hitReg(regAddr, REG_D1LO))   chLo_r[1] <= regWrData;
			if (regWr && hitReg(regAddr, REG_D1HI))   chHi_r[1] <= regWrData;
			if (wrPid) pid_r <= regWrData;
			if (regWr && hitReg(regAddr, REG_MTBASE)) mtBase_r <= regWrData;
			if (regWr && hitReg(regAddr, REG_MTSIZE)) mtSize_r <= regWrData;
			regRdData <= regRd ? rdMux : 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------
	// event input: two stage sync, falling edge
	// ------------------------------------------------------------
	logic evSync1_r, evSync2_r, evSync3_r;
	always_ff @(posedge clk) begin
		if (rst) begin
			evSync1_r <= 1'b1;
			evSync2_r <= 1'b1;
			evSync3_r <= 1'b1;
		end else begin
			evSync1_r <= externalEventInN;
			evSync2_r <= evSync1_r;
			evSync3_r <= evSync2_r;
		end
	end
	wire evFall = evSync3_r && !evSync2_r; // [R22]

	// ------------------------------------------------------------
	// event capture
	// ------------------------------------------------------------
	logic [31:0] lastPc_r, lastDa_r;
	wire [1:0] chHit;
	genvar g;
	for (g = 0; g < 2; g++) begin : g_chan
		assign chHit[g] = cpuMemAcc && ctrl_r[CB_DATA0+g] && inRange(cpuMemAddr, chLo_r[g], chHi_r[g]); // [R8] [R9]
	end
	wire [1:0] chWp   = chHit & {ctrl_r[CB_D1WP], ctrl_r[CB_D0WP]}; // [R12]
	wire       dataEv = |(chHit & ~chWp);
	wire [N_BKPT-1:0] wpHits = bkptTrig & wpEn_r[N_BKPT-1:0]; // [R11]

	logic [N_SRC-1:0] pend_r, take, evt, lost;
	logic [31:0] payA_r [N_SRC];
	logic [31:0] payB_r [N_SRC];
	logic [5:0]  tc_r   [N_SRC];
	logic [31:0] capA   [N_SRC];
	logic [31:0] capB   [N_SRC];
	logic [5:0]  capTc  [N_SRC];
	logic        errTaken;

	assign evt[SRC_DBG]  = cpuDebugEntry && ctrl_r[CB_DBGST]; // [R15]
	assign evt[SRC_OWN]  = wrPid && ctrl_r[CB_OWN]; // [R10]
	assign evt[SRC_WP]   = |wpHits || |chWp;
	assign evt[SRC_SYNC] = (evFall && ctrl_r[CB_EVSYNC]) || errTaken; // [R14] [R18]
	assign evt[SRC_DATA] = dataEv; // [R7]
	assign evt[SRC_PROG] = cpuBranch && ctrl_r[CB_PROG]; // [R6]
	assign lost[0]       = 1'b0;
	for (g = 1; g < N_SRC; g++) begin : g_lost
		assign lost[g] = evt[g] && pend_r[g] && !take[g]; // [R4]
	end
	assign evt[SRC_ERR] = |lost;

	assign capA[SRC_ERR]  = (pend_r[SRC_ERR] && !take[SRC_ERR]) ? (payA_r[SRC_ERR] | 32'(lost)) : 32'(lost);
	assign capB[SRC_ERR]  = '0;
	assign capTc[SRC_ERR] = TC_ERR;
	assign capA[SRC_DBG]  = 32'h0000_0001;
	assign capB[SRC_DBG]  = '0;
	assign capTc[SRC_DBG] = TC_DBG;
	assign capA[SRC_OWN]  = regWrData;
	assign capB[SRC_OWN]  = '0;
	assign capTc[SRC_OWN] = TC_OWN;
	assign capA[SRC_WP]   = {22'h000000, chWp, wpHits};
	assign capB[SRC_WP]   = '0;
	assign capTc[SRC_WP]  = TC_WP;
	assign capA[SRC_SYNC] = lastPc_r;
	assign capB[SRC_SYNC] = lastDa_r;
	assign capTc[SRC_SYNC] = TC_SYNC;
	assign capA[SRC_DATA] = cpuMemAddr;
	assign capB[SRC_DATA] = cpuMemData;
	assign capTc[SRC_DATA] = {TC_DATA, cpuMemWrite, cpuMemSize};
	// program message sends the source XORed with the last target and the target XORed with the source
	assign capA[SRC_PROG] = cpuBranchSrc ^ lastPc_r; // [R2] [R6]
	assign capB[SRC_PROG] = cpuBranchDst ^ cpuBranchSrc;
	assign capTc[SRC_PROG] = TC_PROG;

	for (g = 0; g < N_SRC; g++) begin : g_slot
		always_ff @(posedge clk) begin
			if (rst) begin
				pend_r[g] <= 1'b0;
				payA_r[g] <= '0;
				payB_r[g] <= '0;
				tc_r[g]   <= '0;
			end else begin
				pend_r[g] <= evt[g] || (pend_r[g] && !take[g]);
				if (evt[g] && (!pend_r[g] || take[g] || g == SRC_ERR)) begin
					payA_r[g] <= capA[g];
					payB_r[g] <= capB[g];
					tc_r[g]   <= capTc[g];
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			lastPc_r <= '0;
			lastDa_r <= '0;
		end else begin
			if (evt[SRC_PROG]) lastPc_r <= cpuBranchDst;
			if (evt[SRC_DATA]) lastDa_r <= cpuMemAddr;
		end
	end

	// ------------------------------------------------------------
	// message sequencer into the frame queue
	// ------------------------------------------------------------
	seq_state_type state_r, state_nxt;
	logic [2:0]  pick;
	logic [31:0] curA_r, curB_r;
	logic [5:0]  curTc_r;
	logic        curTwo_r, idx_r;
	logic        qInReady, qOutValid, qOutReady;
	logic [FRAME_W-1:0] qOutFrame;

	always_comb begin
		pick = 3'(N_SRC - 1);
		for (int i = N_SRC - 1; i >= 0; i--)
			if (pend_r[i]) pick = 3'(i);
	end

	wire startMsg = (state_r == ST_IDLE) && |pend_r;
	wire qPush    = (state_r == ST_SEND);
	wire lastFr   = !curTwo_r || idx_r;
	wire msgIns   = qPush && qInReady && !idx_r;
	assign take   = startMsg ? N_SRC'(1) << pick : '0;
	assign errTaken = take[SRC_ERR];
	wire [FRAME_W-1:0] qInFrame = {lastFr, curTc_r, idx_r ? curB_r : curA_r}; // [R2]

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			ST_IDLE: if (startMsg) state_nxt = ST_SEND;
			ST_SEND: if (qInReady && lastFr) state_nxt = ST_IDLE;
			default: state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			state_r  <= ST_IDLE;
			curA_r   <= '0;
			curB_r   <= '0;
			curTc_r  <= '0;
			curTwo_r <= 1'b0;
			idx_r    <= 1'b0;
		end else begin
			state_r <= state_nxt;
			if (startMsg) begin
				curA_r   <= payA_r[pick];
				curB_r   <= payB_r[pick];
				curTc_r  <= tc_r[pick];
				curTwo_r <= (pick == 3'(SRC_PROG)) || (pick == 3'(SRC_DATA)) || (pick == 3'(SRC_SYNC));
				idx_r    <= 1'b0;
			end else if (qPush && qInReady) begin
				idx_r <= !lastFr;
			end
		end
	end

	trace_frame_queue u_queue (
		.clk      (clk),
		.rst      (rst),
		.inValid  (qPush),
		.inReady  (qInReady),
		.inFrame  (qInFrame),
		.outValid (qOutValid),
		.outReady (qOutReady),
		.outFrame (qOutFrame),
		.level    (qLevel)
	); // [R3]

	always_ff @(posedge clk) begin
		if (rst)
			ovf_r <= 1'b0;
		else if (evt[SRC_ERR])
			ovf_r <= 1'b1;
		else if (regWr && hitReg(regAddr, REG_STATUS) && regWrData[8])
			ovf_r <= 1'b0;
	end

	assign cpuStall = ctrl_r[CB_STALL] && (!qInReady || |pend_r); // [R5]

	// ------------------------------------------------------------
	// frame drain: aux port or memory buffer
	// ------------------------------------------------------------
	wire memMode = ctrl_r[CB_MEMTR];
	assign auxValid   = qOutValid && !memMode; // [R3]
	assign auxFrame   = qOutFrame;
	assign memWrValid = qOutValid && memMode; // [R19]
	assign memWrData  = qOutFrame;
	assign memWrAddr  = mtBase_r + mtOff_r;
	assign qOutReady  = memMode ? memWrReady : auxReady;
	wire memPop = memWrValid && memWrReady;

	always_ff @(posedge clk) begin
		if (rst)
			mtOff_r <= '0;
		else if (regWr && hitReg(regAddr, REG_MTBASE))
			mtOff_r <= '0;
		else if (memPop)
			mtOff_r <= (mtOff_r + MT_STEP >= mtSize_r) ? 32'h0000_0000 : mtOff_r + MT_STEP; // [R19]
	end

	// ------------------------------------------------------------
	// breakpoint request and event output
	// ------------------------------------------------------------
	wire brkNow = |(bkptTrig & haltEn_r[N_BKPT-1:0]) || (evFall && ctrl_r[CB_EVBRK]); // [R11] [R13]
	logic evtoLvl_r;
	wire [1:0] evtoMode = ctrl_r[CB_EVTO+1:CB_EVTO];
	wire togMsg = (evtoMode == EVTO_MSG) && msgIns; // [R16]
	wire togBrk = (evtoMode == EVTO_BRK) && (|bkptTrig || cpuDebugEntry); // [R17]

	always_ff @(posedge clk) begin
		if (rst) begin
			cpuBreakReq <= 1'b0;
			evtoLvl_r   <= 1'b0;
		end else begin
			cpuBreakReq <= brkNow;
			evtoLvl_r   <= evtoLvl_r ^ (togMsg || togBrk);
		end
	end
	assign eventOutputToggleN = !evtoLvl_r; // [R22]

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_branch;
		cpuBranch && ctrl_r[CB_PROG];
	endsequence
	sequence s_pidWrite;
		wrPid && ctrl_r[CB_OWN];
	endsequence

	a_trace_off: assert property (@(posedge clk) disable iff (rst) // [R1]
		(ctrl_r == CTRL_RST) |-> !evt[SRC_PROG] && !evt[SRC_DATA] && !evt[SRC_OWN]) else $error("trace while disabled");
	a_prog_pend: assert property (@(posedge clk) disable iff (rst) // [R6]
		s_branch |=> pend_r[SRC_PROG]) else $error("branch not queued");
	// a write that lands while the slot is still busy is lost on purpose and reported instead
	a_own_value: assert property (@(posedge clk) disable iff (rst) // [R10]
		s_pidWrite && (!pend_r[SRC_OWN] || take[SRC_OWN])
		|=> pend_r[SRC_OWN] && payA_r[SRC_OWN] == $past(regWrData)) else $error("ownership value lost");
	a_lost_error: assert property (@(posedge clk) disable iff (rst) // [R4]
		|lost |=> pend_r[SRC_ERR] && ovf_r) else $error("overflow without error");
	a_stall_full: assert property (@(posedge clk) disable iff (rst) // [R5]
		ctrl_r[CB_STALL] && !qInReady |-> cpuStall) else $error("no stall on full queue");
	a_two_frames: assert property (@(posedge clk) disable iff (rst) // [R7]
		startMsg && pick == 3'(SRC_DATA) |=> qPush [*2]) else $error("data message length");
	a_dbg_status: assert property (@(posedge clk) disable iff (rst) // [R15]
		cpuDebugEntry && ctrl_r[CB_DBGST] |=> pend_r[SRC_DBG]) else $error("debug status missing");
	a_evto_msg: assert property (@(posedge clk) disable iff (rst) // [R16]
		togMsg && !togBrk |=> eventOutputToggleN != $past(eventOutputToggleN)) else $error("event out no toggle");
	a_evti_brk: assert property (@(posedge clk) disable iff (rst) // [R13]
		$fell(evSync2_r) && ctrl_r[CB_EVBRK] |=> cpuBreakReq) else $error("event in no break");
	a_mem_wrap: assert property (@(posedge clk) disable iff (rst) // [R19]
		mtSize_r != '0 && !(regWr && hitReg(regAddr, REG_MTBASE)) && mtOff_r < mtSize_r |=> mtOff_r < mtSize_r)
		else $error("memory offset out of buffer");

endmodule // debug_trace_message_unit
`default_nettype wire

//--- test/aux_tool_model.sv
`timescale 1ns/1ps
`default_nettype none
module aux_tool_model (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic [1:0]                    mode,
	input  wire logic                          auxValid,
	input  wire logic [trace_pkg::FRAME_W-1:0] auxFrame,
	output logic                               auxReady
);
	import trace_pkg::*;
	logic [FRAME_W-1:0] q[$];
	logic               tick_r = 1'b0;
	// mode 0 takes every frame, 1 every other cycle, 2 stalls the port
	assign auxReady = !rst && ((mode == 2'h0) || (mode == 2'h1 && tick_r));
	always @(posedge clk) begin
		tick_r <= rst ? 1'b0 : ~tick_r;
		if (auxValid && auxReady) begin
			q.push_back(auxFrame);
		end
	end
endmodule // aux_tool_model
`default_nettype wire

//--- test/debug_trace_message_unit_tb.sv
`timescale 1ns/1ps
`default_nettype none
module debug_trace_message_unit_tb;
	import trace_pkg::*;
	logic               clk = 0, rst = 1, regWr = 0, regRd = 0, cpuBranch = 0, cpuMemAcc = 0;
	logic               cpuMemWrite = 0, cpuDebugEntry = 0, externalEventInN = 1, memWrReady = 1;
	logic [7:0]         regAddr = 0, bkptTrig = 0;
	logic [31:0]        regWrData = 0, cpuBranchSrc = 0, cpuBranchDst = 0, cpuMemAddr = 0, cpuMemData = 0;
	logic [1:0]         cpuMemSize = 0, toolMode = 0;
	logic [31:0]        regRdData, memWrAddr, d;
	logic               cpuStall, cpuBreakReq, evOut, auxValid, auxReady, memWrValid, e0, h;
	logic [FRAME_W-1:0] auxFrame, memWrData, f, g;
	logic [FRAME_W-1:0] mdq[$];
	logic [31:0]        mq[$];
	int                 errors = 0, num_checks = 0;

	always #20 clk = ~clk;

	debug_trace_message_unit uut (.clk(clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .cpuBranch(cpuBranch),
		.cpuBranchSrc(cpuBranchSrc), .cpuBranchDst(cpuBranchDst), .cpuMemAcc(cpuMemAcc),
		.cpuMemWrite(cpuMemWrite), .cpuMemSize(cpuMemSize), .cpuMemAddr(cpuMemAddr),
		.cpuMemData(cpuMemData), .bkptTrig(bkptTrig), .cpuDebugEntry(cpuDebugEntry),
		.cpuStall(cpuStall), .cpuBreakReq(cpuBreakReq), .externalEventInN(externalEventInN),
		.eventOutputToggleN(evOut), .auxValid(auxValid), .auxReady(auxReady), .auxFrame(auxFrame),
		.memWrValid(memWrValid), .memWrReady(memWrReady), .memWrAddr(memWrAddr), .memWrData(memWrData));
	aux_tool_model tool (.clk(clk), .rst(rst), .mode(toolMode), .auxValid(auxValid),
		.auxFrame(auxFrame), .auxReady(auxReady));

	always @(posedge clk) begin
		if (memWrValid && memWrReady) begin
			mq.push_back(memWrAddr);
			mdq.push_back(memWrData);
		end
	end

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic chk(input logic [FRAME_W-1:0] got, input logic [FRAME_W-1:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk); regAddr <= a; regWrData <= v; regWr <= 1;
		@(posedge clk); regWr <= 0;
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk); regAddr <= a; regRd <= 1;
		@(posedge clk); regRd <= 0;
		#1 v = regRdData;
	endtask
	task automatic pop(output logic [FRAME_W-1:0] v);
		int n;
		n = 0;
		while (tool.q.size() == 0 && n < 100) begin
			@(posedge clk); n++;
		end
		if (n == 100) begin
			errors++; v = 'x;
			$display("[FAIL] %0t no frame", $time);
		end else v = tool.q.pop_front();
	endtask
	task automatic branch(input logic [31:0] s, input logic [31:0] t);
		@(posedge clk); cpuBranchSrc <= s; cpuBranchDst <= t; cpuBranch <= 1;
		@(posedge clk); cpuBranch <= 0;
	endtask
	// traced addresses stay clear of the trace buffer at 0x1000
	task automatic dacc(input logic [31:0] a, input logic w, input logic [1:0] s, input logic [31:0] v);
		@(posedge clk); cpuMemAddr <= a; cpuMemWrite <= w; cpuMemSize <= s; cpuMemData <= v; cpuMemAcc <= 1;
		@(posedge clk); cpuMemAcc <= 0;
	endtask
	task automatic dchk(input logic [31:0] a, input logic w, input logic [1:0] s, input logic [31:0] v);
		pop(f); pop(g);
		chk(f[38:32], {1'b0, TC_DATA, w, s});
		chk(g[38:32], {1'b1, TC_DATA, w, s});
		chk(f[31:0], a);
		chk(g[31:0], v);
	endtask
	task automatic brk(output logic hit);
		hit = 0;
		// look once in the current cycle first: the request may already stand
		repeat (8) begin
			#1;
			if (cpuBreakReq === 1'b1) hit = 1;
			@(posedge clk);
		end
	endtask

	// ------------------------------------------------------------
	// tests
	// ------------------------------------------------------------
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		test_done();
	end
	initial begin
		repeat (20) @(posedge clk);
		rst <= 0;
		rd(REG_CTRL, d); chk(d, CTRL_RST);
		rd(REG_MTSIZE, d); chk(d, MTSIZE_RST);
		rd(8'hFC, d); chk(d, 0);
		chk(evOut, 1);
		branch(32'h100, 32'h200); repeat (10) @(posedge clk);
		chk(tool.q.size(), 0);
		$display("test reset done");
		wr(REG_CTRL, 32'h1B);
		branch(32'h1000, 32'h2000); pop(f); chk(f, {1'b0, TC_PROG, 32'h1000});
		pop(f);
		chk(f, {1'b1, TC_PROG, 32'h3000});
		branch(32'h2040, 32'h3000); pop(f); chk(f, {1'b0, TC_PROG, 32'h0040});
		pop(f); chk(f, {1'b1, TC_PROG, 32'h1040});
		$display("test program done");
		wr(REG_D0LO, 32'h80); wr(REG_D0HI, 32'h8F);
		dacc(32'h90, 1, 2'h2, 32'h5); dacc(32'h80, 0, 2'h0, 32'h7A);
		dchk(32'h80, 0, 2'h0, 32'h7A);
		dacc(32'h8F, 1, 2'h2, 32'hCAFE0001); dchk(32'h8F, 1, 2'h2, 32'hCAFE0001);
		$display("test data done");
		wr(REG_CTRL, 32'hDB);
		@(posedge clk); externalEventInN <= 0;
		brk(h); chk(h, 1);
		externalEventInN <= 1;
		pop(f); chk(f, {1'b0, TC_SYNC, 32'h3000});
		pop(f); chk(f, {1'b1, TC_SYNC, 32'h8F});
		$display("test event input done");
		wr(REG_CTRL, 32'h21B); e0 = evOut;
		@(posedge clk); cpuDebugEntry <= 1;
		@(posedge clk); cpuDebugEntry <= 0;
		pop(f); chk(f[38:32], {1'b1, TC_DBG});
		chk(evOut, !e0);
		@(posedge clk); bkptTrig <= 8'h1;
		@(posedge clk); bkptTrig <= 8'h0;
		repeat (4) @(posedge clk); chk(evOut, e0);
		wr(REG_CTRL, 32'h11B); e0 = evOut;
		wr(REG_PID, 32'h55); pop(f); chk(f, {1'b1, TC_OWN, 32'h55});
		chk(evOut, !e0);
		$display("test status and event output done");
		wr(REG_WPEN, 32'h1); wr(REG_HALTEN, 32'h2);
		@(posedge clk); bkptTrig <= 8'h1;
		@(posedge clk); bkptTrig <= 8'h0;
		pop(f); chk(f[38:32], {1'b1, TC_WP}); chk(f[7:0], 8'h1);
		@(posedge clk); bkptTrig <= 8'h2;
		@(posedge clk); bkptTrig <= 8'h0;
		brk(h); chk(h, 1); chk(tool.q.size(), 0);
		wr(REG_D1LO, 32'h40); wr(REG_D1HI, 32'h40); wr(REG_CTRL, 32'h1004);
		dacc(32'h41, 0, 2'h2, 32'h1); dacc(32'h40, 0, 2'h2, 32'h1);
		pop(f); chk(f[38:32], {1'b1, TC_WP}); chk(f[9:8], 2'h2);
		repeat (10) @(posedge clk); chk(tool.q.size(), 0);
		$display("test watchpoint done");
		wr(REG_CTRL, 32'h8); toolMode <= 2;
		for (int i = 0; i < 24; i++) wr(REG_PID, i);
		rd(REG_STATUS, d); chk(d[4:0], 5'h10); chk(d[8], 1);
		toolMode <= 1; repeat (200) @(posedge clk);
		h = 0;
		while (tool.q.size() > 0) begin
			f = tool.q.pop_front();
			if (f[37:32] === TC_ERR) h = 1;
		end
		chk(h, 1);
		rd(REG_STATUS, d); chk(d[4:0], 0);
		wr(REG_STATUS, 32'h100); rd(REG_STATUS, d); chk(d[8], 0);
		$display("test overflow done");
		wr(REG_CTRL, 32'h28); toolMode <= 2;
		// the bench acts as the CPU: after the queue fills it waits out the stall
		for (int i = 0; i < 17; i++) wr(REG_PID, i);
		repeat (2) @(posedge clk);
		chk(cpuStall, 1);
		toolMode <= 0;
		for (int i = 17; i < 20; i++) begin
			while (cpuStall === 1'b1) @(posedge clk);
			wr(REG_PID, i);
		end
		repeat (100) @(posedge clk);
		chk(cpuStall, 0); chk(tool.q.size(), 20);
		rd(REG_STATUS, d); chk(d[8], 0);
		tool.q.delete();
		$display("test stall done");
		wr(REG_MTBASE, 32'h1000); wr(REG_MTSIZE, 32'h10); wr(REG_CTRL, 32'h408); mq.delete(); mdq.delete();
		repeat (3) wr(REG_PID, 32'h9);
		repeat (20) @(posedge clk);
		chk(mq.size(), 3); chk(tool.q.size(), 0);
		chk(mq[0], 32'h1000); chk(mq[1], 32'h1008); chk(mq[2], 32'h1000);
		chk(mdq[2], {1'b1, TC_OWN, 32'h9});
		$display("test memory trace done");
		test_done();
	end
endmodule // debug_trace_message_unit_tb
`default_nettype wire
